// ### bench/annp_mgmt_model.sv
// management controller model on the register port
`timescale 1ns/1ps
module annp_mgmt_model (
  input wire sys_clk_i, // clock
  input wire [15:0] rdata_i, // read data
  input wire rvalid_i, // read valid
  output logic [4:0] addr_o = 5'h00, // address
  output logic wr_o = 1'b0, // write strobe
  output logic [15:0] wdata_o = 16'h0000, // write data
  output logic rd_o = 1'b0 // read strobe
);
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // the answer stands one edge after the strobe; a missing valid leaves
  // unknowns so the caller's compare fails
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int n;
    logic got;
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    d = 16'hxxxx;
    got = 1'b0;
    for (n = 0; n < 4 && !got; n++) begin
      @(posedge sys_clk_i);
      if (rvalid_i === 1'b1) begin
        d = rdata_i;
        got = 1'b1;
      end
    end
  endtask
endmodule // annp_mgmt_model

// ### bench/annp_regs_sva.sv
// port assertions for the next-page register bank
`timescale 1ns/1ps
module annp_regs_sva (
  input wire sys_clk_i, // clock
  input wire resetn_i, // reset, active low
  input wire [4:0] reg_addr_i, // address
  input wire reg_wr_i, // write
  input wire [15:0] reg_wdata_i, // write data
  input wire reg_rd_i, // read
  input wire [15:0] reg_rdata_o, // read data
  input wire lp_np_able_i, // partner np
  input wire page_rx_i, // page in
  input wire [15:0] rx_page_i, // page word
  input wire pd_fault_i, // fault
  input wire tx_sent_i, // sent
  input wire [15:0] tx_page_o, // tx word
  input wire tx_loaded_o // loaded
);
  wire rd6 = reg_rd_i && reg_addr_i == 5'h06;
  wire rd8 = reg_rd_i && reg_addr_i == 5'h08;
  wire calm = !page_rx_i && !pd_fault_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // a read of the flags, then a second read with no new event in between
  sequence quiet_rd6; rd6 && calm ##1 calm [*2] ##1 rd6; endsequence
  sequence page_then_rd8; page_rx_i ##1 !page_rx_i ##1 rd8; endsequence
  np_able_a: assert property (rd6 |=> reg_rdata_o[2])
    else $error("local next-page bit low");
  lp_np_a: assert property (rd6 |=>
    reg_rdata_o[3] == $past(lp_np_able_i, 2))
    else $error("partner next-page bit wrong");
  page_flag_a: assert property (
    page_rx_i ##1 !reg_rd_i ##1 rd6 |=> reg_rdata_o[1])
    else $error("page flag not latched");
  toggle_flip_a: assert property (
    tx_sent_i ##1 !tx_sent_i |=> tx_page_o[11] != $past(tx_page_o[11]))
    else $error("toggle did not flip");
  rx_capture_a: assert property (page_then_rd8 |=>
    reg_rdata_o == ($past(rx_page_i, 3) & 16'hbfff))
    else $error("received page not captured");
  tx_load_a: assert property (reg_wr_i && reg_addr_i == 5'h07 |=>
    tx_loaded_o ##1 tx_page_o[10:0] == $past(reg_wdata_i[10:0], 2))
    else $error("code field not loaded");
  fault_flag_a: assert property (
    pd_fault_i ##1 !reg_rd_i ##1 rd6 |=> reg_rdata_o[4])
    else $error("fault flag not latched");
  read_clear_a: assert property (quiet_rd6 |=>
    !reg_rdata_o[1] && !reg_rdata_o[4])
    else $error("flags survive a read");
endmodule // annp_regs_sva

bind annp_regs annp_regs_sva u_sva (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .lp_np_able_i(lp_np_able_i),
  .page_rx_i(page_rx_i), .rx_page_i(rx_page_i), .pd_fault_i(pd_fault_i),
  .tx_sent_i(tx_sent_i), .tx_page_o(tx_page_o), .tx_loaded_o(tx_loaded_o));

// ### bench/annp_regs_tb.sv
// self-checking bench for the next-page register bank
`timescale 1ns/1ps
module annp_regs_tb;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic lp_an_i = 1'b0;
  logic lp_np_i = 1'b0;
  logic page_i = 1'b0;
  logic [15:0] word_i = 16'h0000;
  logic fault_i = 1'b0;
  logic sent_i = 1'b0;
  wire [4:0] addr;
  wire wr, rd, rvalid, loaded;
  wire [15:0] wdata, rdata, tx_page;
  logic [15:0] v;
  int num_errors = 0;
  int n_tests = 0;
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  annp_regs DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .lp_an_able_i(lp_an_i), .lp_np_able_i(lp_np_i),
    .page_rx_i(page_i), .rx_page_i(word_i), .pd_fault_i(fault_i),
    .tx_sent_i(sent_i), .tx_page_o(tx_page), .tx_loaded_o(loaded));
  annp_mgmt_model m (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    m.rd(a, v);
    chk(v, exp);
  endtask
  task automatic ev(input logic p, f, s, input logic [15:0] w);
    @(posedge sys_clk_i);
    page_i <= p;
    fault_i <= f;
    sent_i <= s;
    word_i <= w;
    @(posedge sys_clk_i);
    page_i <= 1'b0;
    fault_i <= 1'b0;
    sent_i <= 1'b0;
    word_i <= ~w;
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rc(5'h06, 16'h0004);
    rc(5'h07, 16'h2001);
    rc(5'h08, 16'h0000);
    chk(tx_page, 16'h2001);
    lp_np_i <= 1'b1;
    lp_an_i <= 1'b1;
    // read-only places must ignore writes
    m.wr(5'h07, 16'hffff);
    m.wr(5'h06, 16'hffff);
    m.wr(5'h08, 16'hffff);
    rc(5'h06, 16'h000d);
    rc(5'h07, 16'hb7ff);
    rc(5'h08, 16'h0000);
    rc(5'h1f, 16'h0000);
    ev(1'b0, 1'b0, 1'b1, 16'h0000);
    rc(5'h07, 16'hbfff);
    chk(tx_page, 16'hbfff);
    ev(1'b1, 1'b1, 1'b0, 16'hffff);
    rc(5'h06, 16'h001f);
    rc(5'h06, 16'h000d);
    ev(1'b1, 1'b0, 1'b0, 16'h5a5a);
    rc(5'h08, 16'h1a5a);
    lp_np_i <= 1'b0;
    rc(5'h06, 16'h0007);
    close_out;
  end
endmodule // annp_regs_tb

// ### pkg/annp_defs.vh
// constants for the auto-negotiation next-page register bank
// Notes on behaviour
// - expansion bit 2 reads one: the local end is next-page capable.
// - expansion bit 3 follows partner next-page ability; resets to zero.
// - expansion bit 1 latches high when a page arrives; resets to zero.
// - transmit bit 11 flips with each sent page, so it holds the inverse of the last sent word's toggle; resets to zero.
// - transmit bits 10..0 are writable code field, reset value one.
`ifndef ANNP_DEFS_VH
`define ANNP_DEFS_VH

`define ANNP_ADDR_W 5
`define ANNP_DATA_W 16
`define ANNP_ADDR_EXP 5'h06
`define ANNP_ADDR_NPTX 5'h07
`define ANNP_ADDR_NPRX 5'h08

// expansion register fields
`define ANNP_EXP_LP_AN_BIT 0
`define ANNP_EXP_PAGE_RX_BIT 1
`define ANNP_EXP_NP_ABLE_BIT 2
`define ANNP_EXP_LP_NP_BIT 3
`define ANNP_EXP_PD_FAULT_BIT 4
`define ANNP_NP_ABLE_VAL 1'b1

// next-page word fields (transmit and receive share the layout)
`define ANNP_NP_BIT 15
`define ANNP_RSVD_BIT 14
`define ANNP_MP_BIT 13
`define ANNP_ACK2_BIT 12
`define ANNP_TOG_BIT 11
`define ANNP_CODE_MSB 10
`define ANNP_CODE_LSB 0

// reset values
`define ANNP_RST_NP 1'b0
`define ANNP_RST_MP 1'b1
`define ANNP_RST_ACK2 1'b0
`define ANNP_RST_TOG 1'b0
`define ANNP_RST_CODE 11'h001
`define ANNP_RST_WORD 16'h0000
`define ANNP_RST_FLAG 1'b0

// reserved bit 14 of a next-page word always reads zero
`define ANNP_RSVD_VAL 1'b0
`define ANNP_RSVD_MASK 16'hbfff

`endif

// ### rtl/annp_lh_flag.v
// latched-high status flag, cleared by a read, set wins over clear
`timescale 1ns/1ps
`include "annp_defs.vh"
module annp_lh_flag (
  input wire sys_clk_i, // system clock
  input wire resetn_i, // synchronous reset, active low
  input wire set_i, // event pulse
  input wire clr_i, // read of the owning register
  output wire flag_o // latched level
);

  reg flag_ff;
  wire nxt_flag;

  assign nxt_flag = set_i | (flag_ff & ~clr_i);

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      flag_ff <= `ANNP_RST_FLAG;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag_o = flag_ff;

endmodule // annp_lh_flag

// ### rtl/annp_regs.v
// expansion, next-page transmit and partner next-page registers
`timescale 1ns/1ps
`include "annp_defs.vh"
module annp_regs (
  input wire sys_clk_i, // system clock, 10 MHz
  input wire resetn_i, // synchronous reset, active low
  input wire [4:0] reg_addr_i, // register address from management unit
  input wire reg_wr_i, // write strobe, one cycle
  input wire [15:0] reg_wdata_i, // write data
  input wire reg_rd_i, // read strobe, one cycle
  output wire [15:0] reg_rdata_o, // read data, valid with reg_rvalid_o
  output wire reg_rvalid_o, // read data valid pulse
  input wire lp_an_able_i, // partner is auto-negotiation able
  input wire lp_np_able_i, // partner advertised next-page ability
  input wire page_rx_i, // pulse: partner page received
  input wire [15:0] rx_page_i, // received page word, taken with page_rx_i
  input wire pd_fault_i, // pulse: more than one technology detected
  input wire tx_sent_i, // pulse: outgoing next page was sent
  output wire [15:0] tx_page_o, // outgoing next page incl. toggle
  output wire tx_loaded_o // pulse: software wrote a new next page
);

  ////////////////////////////////////////////////////////////////////////
  // decode

  // address compare shared by the strobe decodes
  function sel;
    input [4:0] addr;
    input [4:0] target;
    begin
      sel = (addr == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next-page word packing

  // the reset image and the live image of the transmit word share this,
  // so the reserved bit can never drift between the two
  function [15:0] np_word;
    input np;
    input mp;
    input ack2;
    input tog;
    input [10:0] code;
    begin
      np_word = {np, `ANNP_RSVD_VAL, mp, ack2, tog, code};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // strobes

  wire rd_exp;
  wire wr_nptx;
  assign rd_exp = reg_rd_i & sel(reg_addr_i, `ANNP_ADDR_EXP);
  // read-only registers
  // writes to the expansion and partner-page addresses decode to nothing
  assign wr_nptx = reg_wr_i & sel(reg_addr_i, `ANNP_ADDR_NPTX);

  ////////////////////////////////////////////////////////////////////////
  // latched-high expansion flags

  wire page_rx_flag;
  wire pd_fault_flag;

  annp_lh_flag u_page_rx (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .set_i(page_rx_i),
    .clr_i(rd_exp),
    .flag_o(page_rx_flag)
  );

  annp_lh_flag u_pd_fault (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .set_i(pd_fault_i),
    .clr_i(rd_exp),
    .flag_o(pd_fault_flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // partner status levels

  reg lp_an_ff;
  reg lp_np_ff;

  // one stage so the status bits line up with the latched flags
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      lp_an_ff <= `ANNP_RST_FLAG;
      lp_np_ff <= `ANNP_RST_FLAG;
    end else begin
      lp_an_ff <= lp_an_able_i;
      lp_np_ff <= lp_np_able_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outgoing next page

  reg np_ff;
  reg mp_ff;
  reg ack2_ff;
  reg tog_ff;
  reg [10:0] code_ff;
  reg loaded_ff;

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      np_ff <= `ANNP_RST_NP;
      mp_ff <= `ANNP_RST_MP;
      ack2_ff <= `ANNP_RST_ACK2;
      code_ff <= `ANNP_RST_CODE;
      loaded_ff <= `ANNP_RST_FLAG;
    end else begin
      // tells the serializer a fresh page is waiting
      loaded_ff <= wr_nptx;
      if (wr_nptx) begin
        np_ff <= reg_wdata_i[`ANNP_NP_BIT];
        mp_ff <= reg_wdata_i[`ANNP_MP_BIT];
        ack2_ff <= reg_wdata_i[`ANNP_ACK2_BIT];
        code_ff <= reg_wdata_i[`ANNP_CODE_MSB:`ANNP_CODE_LSB];
      end
    end
  end

  // toggle is hardware-owned; software writes to bit 11 are dropped
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      tog_ff <= `ANNP_RST_TOG;
    end else if (tx_sent_i) begin
      tog_ff <= ~tog_ff;
    end
  end

  wire [15:0] nptx_word;
  assign nptx_word = np_word(np_ff, mp_ff, ack2_ff, tog_ff, code_ff);

  // registered copy so the serializer never sees a half-written word
  reg [15:0] tx_page_ff;
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      tx_page_ff <= np_word(`ANNP_RST_NP, `ANNP_RST_MP, `ANNP_RST_ACK2,
                            `ANNP_RST_TOG, `ANNP_RST_CODE);
    end else begin
      tx_page_ff <= nptx_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // partner next page

  reg [15:0] nprx_ff;
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      nprx_ff <= `ANNP_RST_WORD;
    end else if (page_rx_i) begin
      // capture partner page, reserved bit kept zero
      nprx_ff <= rx_page_i & `ANNP_RSVD_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path

  reg [15:0] exp_word;
  always @* begin
    exp_word = `ANNP_RST_WORD;
    exp_word[`ANNP_EXP_LP_AN_BIT] = lp_an_ff;
    exp_word[`ANNP_EXP_PAGE_RX_BIT] = page_rx_flag;
    exp_word[`ANNP_EXP_NP_ABLE_BIT] = `ANNP_NP_ABLE_VAL;
    exp_word[`ANNP_EXP_LP_NP_BIT] = lp_np_ff;
    exp_word[`ANNP_EXP_PD_FAULT_BIT] = pd_fault_flag;
  end

  reg [15:0] nxt_rdata;
  always @* begin
    case (reg_addr_i)
      `ANNP_ADDR_EXP: nxt_rdata = exp_word;
      `ANNP_ADDR_NPTX: nxt_rdata = nptx_word;
      `ANNP_ADDR_NPRX: nxt_rdata = nprx_ff;
      // addresses outside this bank answer zero
      default: nxt_rdata = `ANNP_RST_WORD;
    endcase
  end

  reg [15:0] rdata_ff;
  reg rvalid_ff;
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rdata_ff <= `ANNP_RST_WORD;
      rvalid_ff <= `ANNP_RST_FLAG;
    end else begin
      rvalid_ff <= reg_rd_i;
      // data holds between reads so a slow master can pick it up late
      if (reg_rd_i) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign tx_page_o = tx_page_ff;
  assign tx_loaded_o = loaded_ff;

endmodule // annp_regs
